// >>> core/isc_core.sv
// interrupt source controller: flags, enables, priority, vectors
`timescale 1ns/10ps
`include "isc_params.svh"
//
// Contract
// - eleven sources, four levels, global enable gate
// - per-input edge or level trigger select
// - edge mode: high then low sets flag
// - edge flag cleared on vectoring
// - level flag not cleared, re-requests while low
// - timer0/1 flags set on overflow, auto-cleared
// - watchdog flag bit3, needs enable bit4
// - timer2 flag left set when taken
// - uart done flags cleared only by software
// - two-wire flag needs global and own enable
// - any enabled keypad pin raises keyboard flag
// - capture flag left set when taken
// - brownout needs select, enable and global
// - each source has fixed vector address
// - two-bit priority, 3 highest
// - preempt only by strictly higher level
// - same level resolved by fixed ranking
// - poll every machine cycle, no memory
module isc_core import isc_pkg::*; (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // external pins (asynchronous)
   input wire logic [1:0] i_ext_irq_pin,
   input wire logic [7:0] i_keypad_pin_n,
   // configuration
   input wire logic [1:0] i_ext_trigger_type,
   input wire logic [7:0] i_keypad_enable,
   input wire logic i_global_irq_enable,
   input wire logic [10:0] i_src_enable,
   input wire logic [10:0] i_priority_low_bit,
   input wire logic [10:0] i_priority_high_bit,
   input wire logic [7:0] i_extended_enable_reg,
   input wire logic [7:0] i_auxiliary_reg,
   // peripheral flags and software clears
   input isc_evt_t i_evt,
   input wire logic [2:0] i_sw_clr,
   input wire logic i_keypad_flag_clr,
   // core handshake
   input isc_core_t i_core,
   // outputs to core
   output logic o_irq_req,
   output logic [15:0] o_vector,
   output logic [3:0] o_src,
   output logic [1:0] o_active_level,
   output logic o_in_service,
   output logic [7:0] o_watchdog_control_reg,
   output logic [1:0] o_ext_request_flag,
   output logic o_timer0_overflow_flag,
   output logic o_timer1_overflow_flag,
   output logic o_keypad_irq
);
   isc_state_s_t st_r, st_nxt;
   logic [1:0] ext_s1_r, ext_s2_r;
   logic [7:0] kp_s1_r, kp_s2_r;
   logic kbf_r;
   logic [10:0] pend;
   logic [1:0] lvl [0:10];
   logic mc_tick;
   logic [1:0] ext_fall;
   logic [15:0] vtab [0:10];

   // fixed vector table by rank order
   assign vtab[0] = `ISC_VEC_EXT0;
   assign vtab[1] = `ISC_VEC_BOD;
   assign vtab[2] = `ISC_VEC_WDT;
   assign vtab[3] = `ISC_VEC_TMR0;
   assign vtab[4] = `ISC_VEC_TWI;
   assign vtab[5] = `ISC_VEC_EXT1;
   assign vtab[6] = `ISC_VEC_KBD;
   assign vtab[7] = `ISC_VEC_TMR1;
   assign vtab[8] = `ISC_VEC_UART;
   assign vtab[9] = `ISC_VEC_TMR2;
   assign vtab[10] = `ISC_VEC_CAP0;

   // two-flop synchronisers; second stage only is read
   always_ff @(posedge i_clk_sys) begin
      ext_s1_r <= i_ext_irq_pin;
      ext_s2_r <= ext_s1_r;
      kp_s1_r <= i_keypad_pin_n;
      kp_s2_r <= kp_s1_r;
   end

   // keyboard flag, set wins over software clear
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         kbf_r <= 1'b0;
      end else begin
         kbf_r <= (kbf_r & ~i_keypad_flag_clr) | (|(~kp_s2_r & i_keypad_enable));
      end
   end

   assign mc_tick = (st_r.mc_cnt == `ISC_MC_CLKS - 4'h1);

   // high sample then low sample, judged only at a machine-cycle boundary
   assign ext_fall = mc_tick ? (st_r.ext_smp & ~ext_s2_r) : 2'h0;

   // per-source priority levels
   genvar g;
   generate
      for (g = 0; g < `ISC_NSRC; g++) begin : g_lvl
         assign lvl[g] = {i_priority_high_bit[g], i_priority_low_bit[g]};
      end
   endgenerate

   // pending requests, gated by own and global enables
   always_comb begin
      logic [10:0] raw;
      raw = '0;
      raw[ISC_EXT0] = st_r.ext_flag[0];
      raw[ISC_EXT1] = st_r.ext_flag[1];
      raw[ISC_TMR0] = st_r.tf0;
      raw[ISC_TMR1] = st_r.tf1;
      raw[ISC_WDT] = st_r.watchdog_irq_flag & i_extended_enable_reg[`ISC_EIE_WDT_BIT];
      raw[ISC_TMR2] = i_evt.tmr2_event;
      raw[ISC_UART] = i_evt.uart_rx_done | i_evt.uart_tx_done;
      raw[ISC_TWI] = i_evt.twi_state_new;
      raw[ISC_KBD] = kbf_r;
      raw[ISC_CAP0] = i_evt.cap0_event;
      raw[ISC_BOD] = i_evt.brownout & i_auxiliary_reg[`ISC_AUX_BOI_BIT]
                     & i_extended_enable_reg[`ISC_EIE_BOD_BIT];
      pend = raw & i_src_enable & {11{i_global_irq_enable}};
   end

   // next-state logic
   always_comb begin
      logic found;
      logic [1:0] best;
      logic [3:0] bsrc;
      st_nxt = st_r;
      found = 1'b0;
      best = 2'h0;
      bsrc = 4'h0;
      st_nxt.mc_cnt = mc_tick ? 4'h0 : st_r.mc_cnt + 4'h1;
      // sample external pins once per machine cycle
      if (mc_tick) begin
         st_nxt.ext_smp = ext_s2_r;
      end
      for (int i = 0; i < 2; i++) begin
         if (i_ext_trigger_type[i]) begin
            st_nxt.ext_flag[i] = ext_fall[i] | st_r.ext_flag[i];
         end else begin
            st_nxt.ext_flag[i] = ~ext_s2_r[i];
         end
      end
      st_nxt.tf0 = st_r.tf0 | i_evt.tmr0_ovf;
      st_nxt.tf1 = st_r.tf1 | i_evt.tmr1_ovf;
      st_nxt.watchdog_irq_flag = (st_r.watchdog_irq_flag & ~i_sw_clr[2]) | i_evt.wdt_timeout;
      if (i_sw_clr[0]) st_nxt.tf0 = i_evt.tmr0_ovf;
      if (i_sw_clr[1]) st_nxt.tf1 = i_evt.tmr1_ovf;
      // fresh poll each machine cycle; lower index wins ties
      for (int i = `ISC_NSRC - 1; i >= 0; i--) begin
         if (pend[i] && (!found || lvl[i] >= best)) begin
            found = 1'b1;
            best = lvl[i];
            bsrc = 4'(i);
         end
      end
      if (mc_tick) begin
         st_nxt.req = found && (st_r.act == 4'h0 || best > st_r.act_top);
         st_nxt.win_src = bsrc;
         st_nxt.vec = vtab[bsrc];
      end
      // core takes the vector: hardware clears where documented
      if (i_core.take && st_r.req && i_core.poll_ok) begin
         st_nxt.req = 1'b0;
         st_nxt.act[lvl[st_r.win_src]] = 1'b1;
         st_nxt.act_top = lvl[st_r.win_src];
         unique case (st_r.win_src)
            ISC_EXT0: if (i_ext_trigger_type[0] && !ext_fall[0]) st_nxt.ext_flag[0] = 1'b0;
            ISC_EXT1: if (i_ext_trigger_type[1] && !ext_fall[1]) st_nxt.ext_flag[1] = 1'b0;
            ISC_TMR0: st_nxt.tf0 = i_evt.tmr0_ovf;
            ISC_TMR1: st_nxt.tf1 = i_evt.tmr1_ovf;
            default: ;
         endcase
         st_nxt.st = ISC_VEC;
      end else if (i_core.reti && st_r.act != 4'h0) begin
         // retire the highest active level
         st_nxt.act[st_r.act_top] = 1'b0;
         st_nxt.act_top = 2'h0;
         for (int k = 0; k < 4; k++) begin
            if (k != st_r.act_top && st_r.act[k]) st_nxt.act_top = 2'(k);
         end
         if ((st_r.act & ~(4'h1 << st_r.act_top)) == 4'h0) st_nxt.st = ISC_IDLE;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_r <= '{ext_smp: 2'h3, st: ISC_IDLE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_irq_req = st_r.req;
   assign o_vector = st_r.vec;
   assign o_src = st_r.win_src;
   assign o_active_level = st_r.act_top;
   assign o_in_service = (st_r.st == ISC_VEC);
   assign o_watchdog_control_reg = 8'(st_r.watchdog_irq_flag) << `ISC_WDT_FLAG_BIT;
   assign o_ext_request_flag = st_r.ext_flag;
   assign o_timer0_overflow_flag = st_r.tf0;
   assign o_timer1_overflow_flag = st_r.tf1;
   assign o_keypad_irq = kbf_r;

   // edge flag drops after being taken
   a_ext_edge_clr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_core.take && st_r.req && i_core.poll_ok && st_r.win_src == 4'h0 && i_ext_trigger_type[0]
       && !ext_fall[0]) |=> !st_r.ext_flag[0])
      else $error("edge flag not cleared");
   a_tmr0_clr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_core.take && st_r.req && i_core.poll_ok && st_r.win_src == 4'h3 && !i_evt.tmr0_ovf)
      |=> !st_r.tf0)
      else $error("timer0 flag not cleared");
   a_tmr0_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_evt.tmr0_ovf |=> st_r.tf0)
      else $error("timer0 flag not set");
   a_no_preempt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (st_r.act != 4'h0 && $rose(st_r.req)) |-> lvl[st_r.win_src] > st_r.act_top)
      else $error("preempted by equal or lower level");
   a_wdt_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (!i_extended_enable_reg[`ISC_EIE_WDT_BIT]) |-> !pend[2])
      else $error("watchdog request without enable");
   a_global_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_global_irq_enable |-> pend == 11'h000)
      else $error("request with global enable off");
   a_vec_map: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (st_r.req && st_r.win_src == 4'h9) |-> st_r.vec == 16'h0043)
      else $error("timer2 vector wrong");
   a_poll_rate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $changed(st_r.req) && !$past(i_core.take) |-> $past(mc_tick))
      else $error("request changed off machine cycle");
   a_kbd_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (kbf_r && !i_keypad_flag_clr) |=> kbf_r)
      else $error("keyboard flag lost");
endmodule : isc_core

// >>> core/isc_params.svh
// constants for the interrupt source controller
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH
`define ISC_NSRC 11
`define ISC_MC_CLKS 4'hC
`define ISC_VEC_EXT0 16'h0003
`define ISC_VEC_BOD 16'h002B
`define ISC_VEC_WDT 16'h0053
`define ISC_VEC_TMR0 16'h000B
`define ISC_VEC_TWI 16'h0033
`define ISC_VEC_EXT1 16'h0013
`define ISC_VEC_KBD 16'h003B
`define ISC_VEC_TMR1 16'h001B
`define ISC_VEC_UART 16'h0023
`define ISC_VEC_TMR2 16'h0043
`define ISC_VEC_CAP0 16'h006B
`define ISC_WDT_FLAG_BIT 3
`define ISC_EIE_WDT_BIT 4
`define ISC_AUX_BOI_BIT 5
`define ISC_EIE_BOD_BIT 6
`endif

// >>> core/isc_pkg.sv
// types for the interrupt source controller
package isc_pkg;
   // source index equals arbitration rank, 0 ranks first
   typedef enum logic [3:0] {
      ISC_EXT0, ISC_BOD, ISC_WDT, ISC_TMR0, ISC_TWI, ISC_EXT1,
      ISC_KBD, ISC_TMR1, ISC_UART, ISC_TMR2, ISC_CAP0
   } isc_src_t;
   // raw event inputs from the peripherals
   typedef struct packed {
      logic tmr0_ovf;
      logic tmr1_ovf;
      logic wdt_timeout;
      logic tmr2_event;
      logic uart_rx_done;
      logic uart_tx_done;
      logic twi_state_new;
      logic cap0_event;
      logic brownout;
   } isc_evt_t;
   // core handshake
   typedef struct packed {
      logic take;
      logic reti;
      logic poll_ok;
   } isc_core_t;
   typedef enum logic [1:0] {ISC_IDLE, ISC_VEC} isc_state_t;
   // module state apart from the synchronisers and the keyboard flag
   typedef struct packed {
      logic [1:0] ext_smp;
      logic [1:0] ext_flag;
      logic tf0;
      logic tf1;
      logic watchdog_irq_flag;
      logic [3:0] mc_cnt;
      logic [3:0] win_src;
      logic [15:0] vec;
      logic req;
      logic [3:0] act;
      logic [1:0] act_top;
      isc_state_t st;
   } isc_state_s_t;
endpackage : isc_pkg

// >>> verif/isc_core_model.sv
// processor core model: fetches vectors and returns after a service span
`timescale 1ns/10ps
module isc_core_model import isc_pkg::*; (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // controller side
   input wire logic i_irq_req,
   input wire logic i_slow,
   output isc_core_t o_core
);
   // poll always allowed; one fetch at a time, no nesting from this side
   initial begin
      o_core = '{take: 1'b0, reti: 1'b0, poll_ok: 1'b1};
      forever begin
         @(negedge i_clk_sys);
         if (!i_rst && i_irq_req) begin
            repeat (i_slow ? 4 : 0) @(negedge i_clk_sys);
            // request may have been dropped meanwhile, so look again
            if (i_irq_req) begin
               o_core.take = 1'b1;
               @(negedge i_clk_sys);
               o_core.take = 1'b0;
               // long enough for several polls while in service
               repeat (40) @(negedge i_clk_sys);
               o_core.reti = 1'b1; // end of service
               @(negedge i_clk_sys);
               o_core.reti = 1'b0;
            end
         end
      end
   end
endmodule : isc_core_model

// >>> verif/tb_isc_core.sv
// self-checking bench for the interrupt source controller
`timescale 1ns/10ps
`include "isc_params.svh"
module tb_isc_core import isc_pkg::*;;
   logic clk, rst, gie, kclr, slow, irq, insv, t0f, t1f, kf;
   logic [1:0] pin, trig, lvl, eflag;
   logic [7:0] kp_n, kp_en, extended_enable_reg, aux, wdc;
   logic [10:0] sen, plo, phi;
   logic [2:0] swc;
   logic [3:0] src;
   logic [15:0] vec;
   isc_evt_t evt;
   isc_core_t core;
   int errors, checks_done, taken, t0;
   logic [15:0] q[$];
   logic [15:0] e;
   logic [15:0] vt [11] = '{`ISC_VEC_EXT0, `ISC_VEC_BOD, `ISC_VEC_WDT, `ISC_VEC_TMR0, `ISC_VEC_TWI,
      `ISC_VEC_EXT1, `ISC_VEC_KBD, `ISC_VEC_TMR1, `ISC_VEC_UART, `ISC_VEC_TMR2, `ISC_VEC_CAP0};
   isc_core dut (.i_clk_sys(clk), .i_rst(rst), .i_ext_irq_pin(pin), .i_keypad_pin_n(kp_n),
      .i_ext_trigger_type(trig), .i_keypad_enable(kp_en), .i_global_irq_enable(gie), .i_src_enable(sen),
      .i_priority_low_bit(plo), .i_priority_high_bit(phi), .i_extended_enable_reg(extended_enable_reg),
      .i_auxiliary_reg(aux), .i_evt(evt), .i_sw_clr(swc), .i_keypad_flag_clr(kclr), .i_core(core),
      .o_irq_req(irq), .o_vector(vec), .o_src(src), .o_active_level(lvl), .o_in_service(insv),
      .o_watchdog_control_reg(wdc), .o_ext_request_flag(eflag), .o_timer0_overflow_flag(t0f),
      .o_timer1_overflow_flag(t1f), .o_keypad_irq(kf));
   isc_core_model core_m (.i_clk_sys(clk), .i_rst(rst), .i_irq_req(irq), .i_slow(slow), .o_core(core));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task print_verdict;
      if (q.size() != 0) errors++;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   // bounded waits: for a count of fetches, then for the end of service
   task wait_take(input int n);
      for (int k = 0; k < 600 && taken < n; k++) @(negedge clk);
      chk(16'(taken), 16'(n));
   endtask : wait_take
   task wait_idle;
      for (int k = 0; k < 300 && insv !== 1'b0; k++) @(negedge clk);
      chk(16'(insv), 16'h0);
   endtask : wait_idle
   // drive one source; pulse events last a single cycle
   task raise(input int s);
      int k;
      k = $urandom % 8;
      case (s)
         0: pin[0] = 1'b0;
         1: evt.brownout = 1'b1;
         2: evt.wdt_timeout = 1'b1;
         3: evt.tmr0_ovf = 1'b1;
         4: evt.twi_state_new = 1'b1;
         5: pin[1] = 1'b0;
         6: begin
            kp_en = 8'($urandom) | (8'h01 << k);
            kp_n[k] = 1'b0;
         end
         7: evt.tmr1_ovf = 1'b1;
         8: if ($urandom % 2) evt.uart_rx_done = 1'b1; else evt.uart_tx_done = 1'b1;
         9: evt.tmr2_event = 1'b1;
         default: evt.cap0_event = 1'b1;
      endcase
      cyc(1);
      {evt.tmr0_ovf, evt.tmr1_ovf, evt.wdt_timeout} = 3'h0;
   endtask : raise
   // software side clears whatever the controller leaves set
   task lower(input int s);
      pin = 2'h3;
      kp_n = 8'hFF;
      {evt.brownout, evt.twi_state_new, evt.uart_rx_done, evt.uart_tx_done} = 4'h0;
      {evt.tmr2_event, evt.cap0_event} = 2'h0;
      cyc(3); // synced keypad pins must read high before the clear
      swc = (s == 2) ? 3'h4 : 3'h0;
      kclr = (s == 6);
      cyc(1);
      swc = 3'h0;
      kclr = 1'b0;
   endtask : lower
   task fire(input int s);
      t0 = taken;
      q.push_back(vt[s]);
      raise(s);
      wait_take(t0 + 1);
      cyc(2);
      chk(16'(insv), 16'h1);
      if (s == 3) chk(16'(t0f), 16'h0);
      if (s == 7) chk(16'(t1f), 16'h0);
      if (s == 0 || s == 5) chk(16'(eflag[s / 5]), 16'h0);
      if (s == 2) chk(16'(wdc[3]), 16'h1);
      if (s == 6) chk(16'(kf), 16'h1);
      lower(s);
      wait_idle;
      cyc(30); // pins stay high a whole machine cycle
   endtask : fire
   // compare each fetched vector against the oldest note
   always @(posedge clk) begin
      if (!rst && core.take && core.poll_ok && irq === 1'b1) begin
         taken++;
         if (q.size() == 0) begin
            chk(vec, 16'hFFFF);
         end else begin
            e = q.pop_front();
            chk(vec, e);
            for (int i = 0; i < 11; i++) begin
               if (vt[i] == e) chk(16'(src), 16'(i));
            end
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict;
   end
   initial begin
      void'($urandom(32'h10CC));
      {rst, gie, pin, trig, kp_n, kp_en} = {1'b1, 1'b1, 2'h3, 2'h3, 8'hFF, 8'hFF};
      {sen, plo, phi, extended_enable_reg, aux, swc, kclr, slow} = {11'h7FF, 22'h0, 8'h50, 8'h20, 3'h0, 1'b0, 1'b0};
      evt = '0;
      cyc(8);
      rst = 1'b0;
      cyc(2);
      for (int s = 0; s < 11; s++) begin
         slow = 1'($urandom);
         fire(s);
      end
      // same level: ranking wins; raised level wins; no same-level preemption
      for (int p = 0; p < 2; p++) begin
         {phi[7], plo[7]} = {1'(p), 1'(p)};
         t0 = taken;
         q.push_back(p ? vt[7] : vt[3]);
         q.push_back(p ? vt[3] : vt[7]);
         {evt.tmr0_ovf, evt.tmr1_ovf} = 2'h3;
         cyc(1);
         {evt.tmr0_ovf, evt.tmr1_ovf} = 2'h0;
         wait_take(t0 + 1);
         cyc(15);
         chk(16'(irq), 16'h0);
         chk(16'(lvl), p ? 16'h3 : 16'h0);
         if (p == 0) begin
            // waiting timer 1 raised above the active level must request
            {phi[7], plo[7]} = 2'h3;
            cyc(13);
            chk(16'(irq), 16'h1);
         end
         wait_take(t0 + 2);
         wait_idle;
      end
      // global enable gates a held timer 2 flag
      gie = 1'b0;
      evt.tmr2_event = 1'b1;
      cyc(40);
      chk(16'(irq), 16'h0);
      t0 = taken;
      q.push_back(vt[9]);
      gie = 1'b1;
      wait_take(t0 + 1);
      evt.tmr2_event = 1'b0;
      wait_idle;
      // brownout without its select bit, then a flag gone before enabling
      aux = 8'h00;
      evt.brownout = 1'b1;
      cyc(40);
      chk(16'(irq), 16'h0);
      evt.brownout = 1'b0;
      cyc(3);
      aux = 8'h20;
      cyc(40);
      chk(16'(irq), 16'h0);
      // watchdog flag set while its enable bit is off
      extended_enable_reg = 8'h40;
      evt.wdt_timeout = 1'b1;
      cyc(1);
      evt.wdt_timeout = 1'b0;
      cyc(40);
      chk(16'(irq), 16'h0);
      chk(16'(wdc[3]), 16'h1);
      swc = 3'h4;
      cyc(1);
      swc = 3'h0;
      extended_enable_reg = 8'h50;
      cyc(2);
      chk(16'(wdc[3]), 16'h0);
      // level mode: pin held low is served again after return
      trig[0] = 1'b0;
      t0 = taken;
      q.push_back(vt[0]);
      q.push_back(vt[0]);
      pin[0] = 1'b0; // held until serviced
      wait_take(t0 + 2);
      chk(16'(eflag[0]), 16'h1);
      pin[0] = 1'b1;
      wait_idle;
      cyc(30);
      print_verdict;
   end
endmodule : tb_isc_core
